// ==== design/bridge_bar_setup_and_clock_ctrl.sv ====
// What this block does
// (RULE_01) window type selector reads 0, memory space, resets to 0
// (RULE_02) address type 00 32-bit, 01 64-bit; prefetch bit; both reset 0
// (RULE_03) size mask bits make base bits writable; resets to all ones
// (RULE_04) window enable resets to 1 and stays 1 when written zero
// (RULE_05) default 4KB size: upper twenty base bits read as ones
// (RULE_06) slot slot_ident_cap_code byte is read-only 04h
// (RULE_07) slot capability next pointer is read-only B0h
// (RULE_08) slot clock fields run for 00/01/10, code 11 stops low
// (RULE_09) device clock bits: 0 runs, 1 stops low; reset 0
// (RULE_10) bridge clock bit acts only in forward mode; 1 stops low
// (RULE_11) read-only status bit 13 shows secondary clock stopped
// (RULE_12) enabled mode 0 stops secondary clock only in D3hot
// (RULE_13) mode 1 stops clock when bus idle and no primary requests
// (RULE_14) translated base bits used follow configured size mask
// (RULE_15) D3hot taken from power state code 11
// (RULE_16) writes to read-only and reserved bits ignored; reserved read 0
// (RULE_17) slot number, first-in-chassis, chassis are plain storage, reset 0
//
// Purpose: configuration registers at 9Ch, A0h, A4h and clock output gating
// Assumes: configuration reads answered combinationally, same cycle
// Notes:   secondary bus status inputs come from core logic on mclk_in
`timescale 1ns/10ps
`default_nettype none
module bridge_bar_setup_and_clock_ctrl
   import bar_clk_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire cfg_req_t    cfg_req_in,
   output logic [31:0]      cfg_rdata_out,
   input  wire logic        forward_mode_in,
   input  wire logic [1:0]  power_state_in,
   input  wire logic        sec_bus_idle_in,
   input  wire logic        primary_req_pending_in,
   input  wire logic        sec_clock_in,
   output logic [18:0]      base_size_mask_out,
   output logic             mem0_prefetch_out,
   output logic [1:0]       mem0_addr_type_out,
   output logic             slot0_clock_output_out,
   output logic             slot1_clock_output_out,
   output logic             slot2_clock_output_out,
   output logic             slot3_clock_output_out,
   output logic             device1_clock_output_out,
   output logic             device2_clock_output_out,
   output logic             bridge_self_clock_output_out,
   output logic             sec_clock_stopped_out
);

   function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic       en);
      merge_byte = en ? new_v : old_v;
   endfunction

   logic [1:0]  addr_type_ff;
   logic [1:0]  nxt_addr_type;
   logic        prefetch_ff;
   logic        nxt_prefetch;
   logic [18:0] size_mask_ff;
   logic [18:0] nxt_size_mask;
   logic [4:0]  slot_num_ff;
   logic [4:0]  nxt_slot_num;
   logic        first_chassis_ff;
   logic        nxt_first_chassis;
   logic [7:0]  chassis_ff;
   logic [7:0]  nxt_chassis;
   clk_ctrl_t   clk_ctrl_ff;
   clk_ctrl_t   nxt_clk_ctrl;
   logic        stop_status_ff;
   logic        nxt_stop_status;

   wire logic        sel_setup = cfg_req_in.addr == OFS_MEM0_SETUP;
   wire logic        sel_slot  = cfg_req_in.addr == OFS_SLOT_IDENT;
   wire logic        sel_clk   = cfg_req_in.addr == OFS_CLK_GATING;
   wire logic        wr_setup  = cfg_req_in.wr && sel_setup;
   wire logic        wr_slot   = cfg_req_in.wr && sel_slot;
   wire logic        wr_clk    = cfg_req_in.wr && sel_clk;
   wire logic [3:0]  be        = cfg_req_in.byte_en;

   // old register images used for byte merging
   wire logic [31:0] setup_img;
   wire logic [31:0] slot_img;
   wire logic [31:0] clk_img;
   wire logic [31:0] setup_new;
   wire logic [31:0] slot_new;
   wire logic [31:0] clk_new;

   assign setup_img = {1'b1, size_mask_ff, 8'h00, prefetch_ff, addr_type_ff, 1'b0}; // RULE_01 RULE_04
   assign slot_img  = {chassis_ff, 2'b00, first_chassis_ff, slot_num_ff,
                       SLOT_NEXT_LINK, SLOT_CAP_CODE}; // RULE_06 RULE_07
   assign clk_img   = {16'h0000, clk_ctrl_ff.stop_mode, clk_ctrl_ff.stop_enable,
                       stop_status_ff, 2'b00, clk_ctrl_ff.self_stop,
                       clk_ctrl_ff.dev2_stop, clk_ctrl_ff.dev1_stop,
                       clk_ctrl_ff.slot3, clk_ctrl_ff.slot2,
                       clk_ctrl_ff.slot1, clk_ctrl_ff.slot0}; // RULE_11 RULE_16

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_merge
         assign setup_new[g*8 +: 8] = merge_byte(setup_img[g*8 +: 8],
                                                 cfg_req_in.wdata[g*8 +: 8], be[g]);
         assign slot_new[g*8 +: 8]  = merge_byte(slot_img[g*8 +: 8],
                                                 cfg_req_in.wdata[g*8 +: 8], be[g]);
         assign clk_new[g*8 +: 8]   = merge_byte(clk_img[g*8 +: 8],
                                                 cfg_req_in.wdata[g*8 +: 8], be[g]);
      end
   endgenerate

   // only writable fields are taken from a write; the rest are rebuilt
   assign nxt_addr_type     = wr_setup ? setup_new[POS_ADDR_TYPE +: 2] : addr_type_ff; // RULE_02
   assign nxt_prefetch      = wr_setup ? setup_new[POS_PREFETCH] : prefetch_ff; // RULE_02
   assign nxt_size_mask     = wr_setup ? setup_new[POS_SIZE_MASK +: 19] : size_mask_ff; // RULE_03
   assign nxt_slot_num      = wr_slot ? slot_new[POS_SLOT_NUM +: 5] : slot_num_ff; // RULE_17
   assign nxt_first_chassis = wr_slot ? slot_new[POS_FIRST_CHASSIS] : first_chassis_ff; // RULE_17
   assign nxt_chassis       = wr_slot ? slot_new[POS_CHASSIS +: 8] : chassis_ff; // RULE_17

   always_comb begin
      nxt_clk_ctrl = clk_ctrl_ff;
      if (wr_clk) begin
         nxt_clk_ctrl.slot0       = clk_new[1:0]; // RULE_08
         nxt_clk_ctrl.slot1       = clk_new[3:2]; // RULE_08
         nxt_clk_ctrl.slot2       = clk_new[5:4]; // RULE_08
         nxt_clk_ctrl.slot3       = clk_new[7:6]; // RULE_08
         nxt_clk_ctrl.dev1_stop   = clk_new[POS_DEV1_CLK]; // RULE_09
         nxt_clk_ctrl.dev2_stop   = clk_new[POS_DEV2_CLK]; // RULE_09
         nxt_clk_ctrl.self_stop   = clk_new[POS_SELF_CLK]; // RULE_10
         nxt_clk_ctrl.stop_enable = clk_new[POS_STOP_ENABLE]; // RULE_12
         nxt_clk_ctrl.stop_mode   = clk_new[POS_STOP_MODE]; // RULE_12
      end
   end

   // secondary clock stop decision
   wire logic in_d3hot  = power_state_in == PWR_STATE_D3; // RULE_15
   wire logic stop_cond = clk_ctrl_ff.stop_enable &&
                          (clk_ctrl_ff.stop_mode ? (sec_bus_idle_in && !primary_req_pending_in)
                                                 : in_d3hot); // RULE_12 RULE_13
   assign nxt_stop_status = stop_cond;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         addr_type_ff     <= RST_ADDR_TYPE;
         prefetch_ff      <= RST_PREFETCH;
         size_mask_ff     <= RST_SIZE_MASK;
         slot_num_ff      <= 5'h00;
         first_chassis_ff <= 1'b0;
         chassis_ff       <= 8'h00;
         clk_ctrl_ff      <= '0;
         stop_status_ff   <= 1'b0;
      end else begin
         addr_type_ff     <= nxt_addr_type;
         prefetch_ff      <= nxt_prefetch;
         size_mask_ff     <= nxt_size_mask;
         slot_num_ff      <= nxt_slot_num;
         first_chassis_ff <= nxt_first_chassis;
         chassis_ff       <= nxt_chassis;
         clk_ctrl_ff      <= nxt_clk_ctrl;
         stop_status_ff   <= nxt_stop_status; // RULE_11
      end
   end

   // read mux; unmapped offsets read zero
   assign cfg_rdata_out = !cfg_req_in.rd ? 32'h0000_0000 :
                          sel_setup ? setup_img :
                          sel_slot  ? slot_img  :
                          sel_clk   ? clk_img   : 32'h0000_0000; // RULE_16 RULE_05

   assign base_size_mask_out = size_mask_ff; // RULE_14
   assign mem0_prefetch_out  = prefetch_ff;
   assign mem0_addr_type_out = addr_type_ff;
   assign sec_clock_stopped_out = stop_status_ff;

   wire logic sec_run = !stop_status_ff;
   assign slot0_clock_output_out   = sec_clock_in && sec_run && clk_ctrl_ff.slot0 != SLOT_CLK_STOP; // RULE_08
   assign slot1_clock_output_out   = sec_clock_in && sec_run && clk_ctrl_ff.slot1 != SLOT_CLK_STOP; // RULE_08
   assign slot2_clock_output_out   = sec_clock_in && sec_run && clk_ctrl_ff.slot2 != SLOT_CLK_STOP; // RULE_08
   assign slot3_clock_output_out   = sec_clock_in && sec_run && clk_ctrl_ff.slot3 != SLOT_CLK_STOP; // RULE_08
   assign device1_clock_output_out = sec_clock_in && sec_run && !clk_ctrl_ff.dev1_stop; // RULE_09
   assign device2_clock_output_out = sec_clock_in && sec_run && !clk_ctrl_ff.dev2_stop; // RULE_09
   assign bridge_self_clock_output_out = sec_clock_in && sec_run &&
                                         !(forward_mode_in && clk_ctrl_ff.self_stop); // RULE_10

   // checks
   a_type_reads_zero: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_01
      (cfg_req_in.rd && sel_setup)
      |-> cfg_rdata_out[0] == 1'b0)
      else $error("type selector not zero");

   a_enable_stays_one: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_04
      (cfg_req_in.rd && sel_setup)
      |-> cfg_rdata_out[POS_WIN_ENABLE])
      else $error("window enable dropped");

   a_addr_type_wr: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_02
      (wr_setup && be[0])
      |=> addr_type_ff == $past(cfg_req_in.wdata[2:1]))
      else $error("address type not stored");

   a_mask_default: assert property (@(posedge mclk_in) // RULE_03 RULE_05
      $fell(rst_in)
      |-> size_mask_ff == RST_SIZE_MASK)
      else $error("size mask not all ones after reset");

   a_cap_bytes: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_06 RULE_07
      (cfg_req_in.rd && sel_slot)
      |-> cfg_rdata_out[15:0] == 16'hB004)
      else $error("slot capability header wrong");

   a_slot_stop_low: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_08
      clk_ctrl_ff.slot2 == SLOT_CLK_STOP
      |-> !slot2_clock_output_out)
      else $error("slot clock not held low");

   a_dev_stop_low: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_09
      clk_ctrl_ff.dev1_stop
      |-> !device1_clock_output_out)
      else $error("device clock not held low");

   a_self_reverse: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_10
      (!forward_mode_in && sec_run)
      |-> bridge_self_clock_output_out == sec_clock_in)
      else $error("bridge clock gated in reverse mode");

   a_mode0_d3: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_12 RULE_15
      (clk_ctrl_ff.stop_enable && !clk_ctrl_ff.stop_mode && in_d3hot)
      |=> stop_status_ff)
      else $error("clock not stopped in D3hot");

   a_mode1_idle: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_13
      (clk_ctrl_ff.stop_enable && clk_ctrl_ff.stop_mode && !sec_bus_idle_in)
      |=> !stop_status_ff)
      else $error("clock stopped while bus busy");

   a_status_read: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_11 RULE_16
      (cfg_req_in.rd && sel_clk)
      |-> cfg_rdata_out[POS_STOP_STATUS] == stop_status_ff
          && cfg_rdata_out[31:16] == 16'h0000)
      else $error("clock status read wrong");

   a_chassis_store: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_17
      (wr_slot && be[3])
      |=> chassis_ff == $past(cfg_req_in.wdata[31:24]))
      else $error("chassis number not stored");

   a_prefetch_wr: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_02
      (wr_setup && be[0])
      |=> prefetch_ff == $past(cfg_req_in.wdata[3]))
      else $error("prefetch bit not stored");

   a_mask_wr_low: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_03
      (wr_setup && be[1])
      |=> size_mask_ff[3:0] == $past(cfg_req_in.wdata[15:12]))
      else $error("size mask low nibble not stored");

   a_mask_hold: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_03
      !wr_setup
      |=> size_mask_ff == $past(size_mask_ff))
      else $error("size mask changed without write");

   a_setup_rsvd: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_16
      (cfg_req_in.rd && sel_setup)
      |-> cfg_rdata_out[11:4] == 8'h00)
      else $error("setup reserved bits not zero");

   a_setup_mask_rd: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_03
      (cfg_req_in.rd && sel_setup)
      |-> cfg_rdata_out[30:12] == size_mask_ff)
      else $error("size mask read wrong");

   a_slot_rsvd: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_16
      (cfg_req_in.rd && sel_slot)
      |-> cfg_rdata_out[23:22] == 2'b00)
      else $error("slot reserved bits not zero");

   a_slot_num_wr: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_17
      (wr_slot && be[2])
      |=> slot_num_ff == $past(cfg_req_in.wdata[20:16]))
      else $error("slot number not stored");

   a_first_chassis: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_17
      (wr_slot && be[2])
      |=> first_chassis_ff == $past(cfg_req_in.wdata[21]))
      else $error("first in chassis not stored");

   a_clk_rsvd: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_16
      (cfg_req_in.rd && sel_clk)
      |-> cfg_rdata_out[12:11] == 2'b00)
      else $error("clock reserved bits not zero");

   a_unmapped_zero: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_16
      (cfg_req_in.rd && !sel_setup && !sel_slot && !sel_clk)
      |-> cfg_rdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_idle_rd_zero: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_16
      !cfg_req_in.rd
      |-> cfg_rdata_out == 32'h0000_0000)
      else $error("read data without read");

   a_slot0_stop: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_08
      clk_ctrl_ff.slot0 == SLOT_CLK_STOP
      |-> !slot0_clock_output_out)
      else $error("slot0 clock not held low");

   a_slot1_stop: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_08
      clk_ctrl_ff.slot1 == SLOT_CLK_STOP
      |-> !slot1_clock_output_out)
      else $error("slot1 clock not held low");

   a_slot3_stop: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_08
      clk_ctrl_ff.slot3 == SLOT_CLK_STOP
      |-> !slot3_clock_output_out)
      else $error("slot3 clock not held low");

   a_slot_run: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_08
      (sec_run && clk_ctrl_ff.slot0 != SLOT_CLK_STOP)
      |-> slot0_clock_output_out == sec_clock_in)
      else $error("slot0 clock not running");

   a_dev2_stop: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_09
      clk_ctrl_ff.dev2_stop
      |-> !device2_clock_output_out)
      else $error("device2 clock not held low");

   a_self_fwd_stop: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_10
      (forward_mode_in && clk_ctrl_ff.self_stop)
      |-> !bridge_self_clock_output_out)
      else $error("bridge clock not held low");

   a_stopped_low: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_12 RULE_13
      stop_status_ff
      |-> !(slot0_clock_output_out || device1_clock_output_out || bridge_self_clock_output_out))
      else $error("clock running while stopped");

   a_stop_off: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_12
      !clk_ctrl_ff.stop_enable
      |=> !stop_status_ff)
      else $error("clock stopped with protocol off");

   a_mode0_awake: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_12
      (clk_ctrl_ff.stop_enable && !clk_ctrl_ff.stop_mode && !in_d3hot)
      |=> !stop_status_ff)
      else $error("clock stopped outside D3hot");

   a_mode1_stop: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_13
      (clk_ctrl_ff.stop_enable && clk_ctrl_ff.stop_mode
       && sec_bus_idle_in && !primary_req_pending_in)
      |=> stop_status_ff)
      else $error("clock not stopped on idle bus");

   a_mode1_pending: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_13
      (clk_ctrl_ff.stop_enable && clk_ctrl_ff.stop_mode && primary_req_pending_in)
      |=> !stop_status_ff)
      else $error("clock stopped with request pending");

endmodule
`default_nettype wire

// ==== design/bar_clk_pkg.sv ====
// Purpose: constants and carriers for window setup, slot id and clock gating registers
// Assumes: dword configuration access, byte enables per lane
// Notes:   offsets are byte addresses in configuration space
package bar_clk_pkg;
   localparam logic [7:0]  OFS_MEM0_SETUP    = 8'h9C;
   localparam logic [7:0]  OFS_SLOT_IDENT    = 8'hA0;
   localparam logic [7:0]  OFS_CLK_GATING    = 8'hA4;
   localparam logic [7:0]  SLOT_CAP_CODE     = 8'h04;
   localparam logic [7:0]  SLOT_NEXT_LINK    = 8'hB0;
   localparam logic [18:0] RST_SIZE_MASK     = 19'h7_FFFF;
   localparam logic [1:0]  RST_ADDR_TYPE     = 2'h0;
   localparam logic        RST_PREFETCH      = 1'b0;
   localparam logic [1:0]  ADDR_TYPE_32      = 2'h0;
   localparam logic [1:0]  ADDR_TYPE_64      = 2'h1;
   localparam logic [1:0]  SLOT_CLK_STOP     = 2'h3;
   localparam logic [1:0]  PWR_STATE_D3      = 2'h3;
   localparam int          POS_ADDR_TYPE     = 1;
   localparam int          POS_PREFETCH      = 3;
   localparam int          POS_SIZE_MASK     = 12;
   localparam int          POS_WIN_ENABLE    = 31;
   localparam int          POS_SLOT_NUM      = 16;
   localparam int          POS_FIRST_CHASSIS = 21;
   localparam int          POS_CHASSIS       = 24;
   localparam int          POS_DEV1_CLK      = 8;
   localparam int          POS_DEV2_CLK      = 9;
   localparam int          POS_SELF_CLK      = 10;
   localparam int          POS_STOP_STATUS   = 13;
   localparam int          POS_STOP_ENABLE   = 14;
   localparam int          POS_STOP_MODE     = 15;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [3:0]  byte_en;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic [1:0] slot3;
      logic [1:0] slot2;
      logic [1:0] slot1;
      logic [1:0] slot0;
      logic       dev1_stop;
      logic       dev2_stop;
      logic       self_stop;
      logic       stop_enable;
      logic       stop_mode;
   } clk_ctrl_t;
endpackage

// ==== verif/sec_side_model.sv ====
// Purpose: far side of the block, secondary clock source and bus status
// Assumes: secondary source clock runs free, unrelated in phase to mclk_in
// Notes:   bus status moves only at falling mclk_in edges
`timescale 1ns/10ps
`default_nettype none
module sec_side_model (
   input  wire logic mclk_in,
   input  wire logic want_idle_in,
   input  wire logic want_pend_in,
   output logic      sec_clock_out,
   output logic      sec_bus_idle_out,
   output logic      primary_req_pending_out
);
   initial begin
      sec_clock_out = 1'b0;
      forever #7.5 sec_clock_out = ~sec_clock_out;
   end
   initial begin
      sec_bus_idle_out = 1'b0;
      primary_req_pending_out = 1'b1;
   end
   always @(negedge mclk_in) begin
      sec_bus_idle_out <= want_idle_in;
      primary_req_pending_out <= want_pend_in;
   end
endmodule
`default_nettype wire

// ==== verif/bridge_bar_setup_and_clock_ctrl_tb_top.sv ====
// Purpose: self-checking bench for window setup, slot id and clock gating
// Assumes: reads combinational, stop status one cycle behind its cause
// Notes:   register model kept in plain words, compared at every read
`timescale 1ns/10ps
`default_nettype none
module bridge_bar_setup_and_clock_ctrl_tb_top;
   import bar_clk_pkg::*;
   logic        mclk_in, rst_in, fwd, want_idle, want_pend, sclk, idle, pend, stopped, pf_o;
   logic [1:0]  pwr, at_o;
   cfg_req_t    req;
   logic [31:0] rdata, lfsr, m9c, ma0, ma4;
   logic [18:0] mask_o;
   logic [6:0]  clk_o;
   logic [7:0]  ofs [4] = '{OFS_MEM0_SETUP, OFS_SLOT_IDENT, OFS_CLK_GATING, 8'hA8};
   logic [4:0]  stp [7] = '{5'h19, 5'h12, 5'h14, 5'h1A, 5'h1B, 5'h0E, 5'h1D};
   int          fail_count, n_tests;
   sec_side_model u_sec_side_model (.mclk_in(mclk_in), .want_idle_in(want_idle),
      .want_pend_in(want_pend), .sec_clock_out(sclk), .sec_bus_idle_out(idle),
      .primary_req_pending_out(pend));
   bridge_bar_setup_and_clock_ctrl u_bridge_bar_setup_and_clock_ctrl (.mclk_in(mclk_in),
      .rst_in(rst_in), .cfg_req_in(req), .cfg_rdata_out(rdata), .forward_mode_in(fwd),
      .power_state_in(pwr), .sec_bus_idle_in(idle), .primary_req_pending_in(pend),
      .sec_clock_in(sclk), .base_size_mask_out(mask_o), .mem0_prefetch_out(pf_o),
      .mem0_addr_type_out(at_o), .slot0_clock_output_out(clk_o[0]),
      .slot1_clock_output_out(clk_o[1]), .slot2_clock_output_out(clk_o[2]),
      .slot3_clock_output_out(clk_o[3]), .device1_clock_output_out(clk_o[4]),
      .device2_clock_output_out(clk_o[5]), .bridge_self_clock_output_out(clk_o[6]),
      .sec_clock_stopped_out(stopped));
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   function automatic logic [31:0] nxt_lfsr(input logic [31:0] v);
      nxt_lfsr = {v[30:0], 1'b0} ^ (v[31] ? 32'h0400_0007 : 32'h0000_0000);
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] o, d, be, wm);
      for (int b = 0; b < 4; b++) wm[8*b +: 8] = wm[8*b +: 8] & {8{be[b]}};
      merge = (o & ~wm) | (d & wm);
   endfunction
   function automatic logic stop_exp();
      stop_exp = ma4[14] && (ma4[15] ? (idle && !pend) : (pwr == PWR_STATE_D3));
   endfunction
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      case (a)
         OFS_MEM0_SETUP: exp_rd = m9c;
         OFS_SLOT_IDENT: exp_rd = ma0;
         OFS_CLK_GATING: exp_rd = ma4 | {18'h0, stop_exp(), 13'h0};
         default:        exp_rd = 32'h0000_0000;
      endcase
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge mclk_in);
      req = '{rd: 1'b0, wr: 1'b1, addr: a, byte_en: be, wdata: d};
      @(negedge mclk_in);
      req.wr = 1'b0;
      if (a == OFS_MEM0_SETUP) m9c = merge(m9c, d, be, 32'h7FFF_F00E);
      if (a == OFS_SLOT_IDENT) ma0 = merge(ma0, d, be, 32'hFF3F_0000);
      if (a == OFS_CLK_GATING) ma4 = merge(ma4, d, be, 32'h0000_C7FF);
   endtask
   task automatic cfg_chk(input logic [7:0] a);
      @(negedge mclk_in);
      req.rd = 1'b1;
      req.addr = a;
      #5;
      chk(rdata, exp_rd(a));
      @(negedge mclk_in);
      req.rd = 1'b0;
   endtask
   task automatic clk_chk();
      logic [6:0] run;
      repeat (2) @(negedge mclk_in);
      for (int i = 0; i < 4; i++) run[i] = ma4[2*i +: 2] != SLOT_CLK_STOP;
      run[4] = !ma4[8];
      run[5] = !ma4[9];
      run[6] = !ma4[10] || !fwd;
      if (stop_exp()) run = 7'h00;
      repeat (4) begin
         #3.7;
         chk(clk_o, {7{sclk}} & run);
      end
      chk(stopped, stop_exp());
      chk({mask_o, pf_o, at_o}, {m9c[30:12], m9c[3], m9c[2:1]});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100us;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      fail_count = 0;
      n_tests = 0;
      lfsr = 32'h4056_6959;
      req = '0;
      {fwd, pwr, want_idle, want_pend, rst_in} = 6'b100011;
      m9c = 32'hFFFF_F000;
      ma0 = {16'h0, SLOT_NEXT_LINK, SLOT_CAP_CODE};
      ma4 = 32'h0000_0000;
      repeat (5) @(negedge mclk_in);
      rst_in = 1'b0;
      foreach (ofs[i]) cfg_chk(ofs[i]);
      clk_chk();
      cfg_wr(OFS_MEM0_SETUP, 4'hF, {29'h0, ADDR_TYPE_64, 1'b1});
      cfg_chk(OFS_MEM0_SETUP);
      clk_chk();
      for (int k = 0; k < 4; k++) begin
         fwd = k[0];
         cfg_wr(OFS_CLK_GATING, 4'h3, {21'h0, k[0], k[1], k[0], {4{k[1:0]}}});
         clk_chk();
         cfg_chk(OFS_CLK_GATING);
      end
      for (int i = 0; i < 24; i++) begin
         lfsr = nxt_lfsr(lfsr);
         cfg_wr(ofs[i % 4], lfsr[3:0], nxt_lfsr(lfsr));
         lfsr = nxt_lfsr(lfsr);
         clk_chk();
         cfg_chk(ofs[i % 4]);
      end
      foreach (stp[i]) begin
         {pwr, want_idle, want_pend} = {stp[i][2] ? PWR_STATE_D3 : 2'h0, stp[i][1:0]};
         cfg_wr(OFS_CLK_GATING, 4'h2, {16'h0, stp[i][3], stp[i][4], 14'h0});
         clk_chk();
         cfg_chk(OFS_CLK_GATING);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
